/* File: hw/stp_dscp_pkg.sv */
package stp_dscp_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_GLOBAL = 8'h02; // flush strobes
  localparam logic [7:0] IDX_TAIL = 8'h03; // processor port options
  localparam logic [7:0] IDX_P1_CTRL = 8'h12; // port 1 stp controls
  localparam logic [7:0] IDX_P2_CTRL = 8'h22; // port 2 stp controls
  localparam logic [7:0] IDX_TOS_FIRST = 8'h60; // first code-point table byte
  localparam logic [7:0] IDX_TOS_LAST = 8'h6F; // last code-point table byte
  localparam logic [7:0] IDX_STATUS = 8'h70; // last decision, read only
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLUSH_DYN_BIT = 4;
  localparam int FLUSH_STA_BIT = 5;
  localparam int TAIL_EN_BIT = 6;
  localparam int TX_EN_BIT = 2;
  localparam int RX_EN_BIT = 1;
  localparam int LRN_DIS_BIT = 0;
  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [2:0] PORT_CTRL_RST = 3'h6; // forwarding state
  localparam logic TAIL_EN_RST = 1'b0;
  localparam logic [7:0] TOS_RST = 8'h00;
  // ----------------------------------------------------------------
  // bus answers, ports, tail codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] SRC_P1 = 2'h1;
  localparam logic [1:0] SRC_P2 = 2'h2;
  localparam logic [1:0] SRC_CPU = 2'h3;
  localparam logic [2:0] MASK_CPU = 3'h4; // bit0 port1, bit1 port2, bit2 port3
  localparam logic [1:0] TAIL_LOOKUP = 2'h0;

  // frame presented by the lookup engine, one per valid cycle
  typedef struct packed {
    logic valid;
    logic [1:0] src; // ingress port 1..3
    logic [2:0] dst; // lookup result mask
    logic ovr; // static entry hit with override bit
    logic is_ip;
    logic [7:0] tos;
    logic [7:0] tail; // tail byte of a processor frame
  } frame_t;

  // decision returned one cycle later
  typedef struct packed {
    logic valid;
    logic [2:0] fwd;
    logic learn;
    logic [1:0] prio;
  } dec_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;
endpackage

/* File: hw/dscp_prio_map.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// code-point to priority lookup
// ------------------------------------------------------------------
module dscp_prio_map #(
  parameter int CP_W = 6,
  parameter int PRIO_W = 2
) (
  input wire logic [(2**CP_W)*PRIO_W-1:0] i_tbl, // packed table, code point 0 lowest
  input wire logic [7:0] i_tos, // whole tos byte
  output logic [PRIO_W-1:0] o_prio
);
  logic [CP_W-1:0] cp; // upper bits of tos select the entry

  // fully decoded: every code point owns its own field
  always_comb begin
    cp = i_tos[7:8-CP_W];
    o_prio = i_tbl[cp*PRIO_W +: PRIO_W];
  end
endmodule

/* File: hw/stp_port_gate.sv */
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - ip frames take priority from code-point table, except tagged processor frames
// - table lives in writable registers 96 to 111
// - port 3 is processor, never stp gated
// - per-port tx, rx, learn-disable in 18, 34
// - disabled port passes no user traffic, learns nothing
// - blocking forwards only frames to processor
// - listening passes only processor traffic, no learning
// - learning state learns but forwards processor traffic
// - forwarding state forwards, receives and learns normally
// - override static hit from port 1 or 2 always reaches processor
// - register 2 bits 5,4 flush learn-disabled ports
// - discarding uses tx 0, rx 0, learn-disable 1
// - processor tail byte low bits pick destination
// - tail tagging enabled by register 3 bit 6
module stp_port_gate #(
  parameter int ADDR_W = 9
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  input wire stp_dscp_pkg::frame_t i_frm,
  output stp_dscp_pkg::dec_t o_dec,
  output logic o_flush_dyn,
  output logic o_flush_sta,
  output logic [1:0] o_flush_ports
);
  import stp_dscp_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = 8'(addr[ADDR_W-1:2]); // low address bits ignored
  endfunction

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == IDX_GLOBAL) || (idx == IDX_TAIL) || (idx == IDX_P1_CTRL) ||
      (idx == IDX_P2_CTRL) || (idx == IDX_STATUS) ||
      (idx >= IDX_TOS_FIRST && idx <= IDX_TOS_LAST);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  wr_state_t wr_state, next_wr_state; // write response sequencer
  logic aw_full, next_aw_full; // address held
  logic w_full, next_w_full; // data held
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane, next_w_lane; // low byte lane enabled
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [2:0] pctl [2], next_pctl [2]; // {tx_en, rx_en, lrn_dis} per port
  logic tail_en, next_tail_en;
  logic [15:0][7:0] tos, next_tos; // code-point table bytes
  logic flush_dyn, next_flush_dyn;
  logic flush_sta, next_flush_sta;
  logic [1:0] flush_ports, next_flush_ports;
  dec_t dec, next_dec;
  logic do_write; // both halves held, apply now
  logic [7:0] widx, ridx;
  logic [1:0] tx_en, rx_en, lrn_dis; // per port, bit0 = port 1
  logic [1:0] dscp_prio; // lookup result for the current frame

  // ----------------------------------------------------------------
  // code-point lookup
  // ----------------------------------------------------------------
  dscp_prio_map #(.CP_W(6), .PRIO_W(2)) u_map (
    .i_tbl(tos),
    .i_tos(i_frm.tos),
    .o_prio(dscp_prio)
  );

  // per-port control fields as vectors
  for (genvar p = 0; p < 2; p++) begin : g_port
    assign tx_en[p] = pctl[p][TX_EN_BIT];
    assign rx_en[p] = pctl[p][RX_EN_BIT];
    assign lrn_dis[p] = pctl[p][LRN_DIS_BIT];
  end

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  assign do_write = aw_full && w_full && (wr_state == WR_IDLE);
  assign o_s_axi_awready = !aw_full && (wr_state == WR_IDLE);
  assign o_s_axi_wready = !w_full && (wr_state == WR_IDLE);
  assign o_s_axi_bvalid = (wr_state == WR_RESP);
  assign o_s_axi_bresp = bresp;
  assign widx = reg_index(aw_addr);

  // address and data are taken in either order, then applied together
  always_comb begin
    next_wr_state = wr_state;
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_bresp = bresp;
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_byte = i_s_axi_wdata[7:0];
      next_w_lane = i_s_axi_wstrb[0];
    end
    case (wr_state)
      WR_IDLE: begin
        if (do_write) begin
          next_wr_state = WR_RESP;
          next_aw_full = 1'b0;
          next_w_full = 1'b0;
          next_bresp = is_mapped(widx) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      WR_RESP: begin
        if (i_s_axi_bready) begin
          next_wr_state = WR_IDLE;
        end
      end
      default: begin
        next_wr_state = WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_state <= WR_IDLE;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      wr_state <= next_wr_state;
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane <= next_w_lane;
      bresp <= next_bresp;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers and flush strobes
  // ----------------------------------------------------------------
  // flush bits are strobes, not storage: they read back as zero
  always_comb begin
    next_pctl = pctl;
    next_tail_en = tail_en;
    next_tos = tos;
    next_flush_dyn = 1'b0;
    next_flush_sta = 1'b0;
    next_flush_ports = lrn_dis;
    if (do_write && w_lane) begin
      if (widx == IDX_GLOBAL) begin
        // only ports with learning disabled are flushed
        next_flush_dyn = w_byte[FLUSH_DYN_BIT] && (|lrn_dis);
        next_flush_sta = w_byte[FLUSH_STA_BIT] && (|lrn_dis);
      end else if (widx == IDX_TAIL) begin
        next_tail_en = w_byte[TAIL_EN_BIT];
      end else if (widx == IDX_P1_CTRL) begin
        next_pctl[0] = w_byte[2:0];
      end else if (widx == IDX_P2_CTRL) begin
        next_pctl[1] = w_byte[2:0];
      end else if (widx >= IDX_TOS_FIRST && widx <= IDX_TOS_LAST) begin
        next_tos[widx[3:0]] = w_byte;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pctl[0] <= PORT_CTRL_RST;
      pctl[1] <= PORT_CTRL_RST;
      tail_en <= TAIL_EN_RST;
      tos <= {16{TOS_RST}};
      flush_dyn <= 1'b0;
      flush_sta <= 1'b0;
      flush_ports <= 2'h0;
    end else begin
      pctl <= next_pctl;
      tail_en <= next_tail_en;
      tos <= next_tos;
      flush_dyn <= next_flush_dyn;
      flush_sta <= next_flush_sta;
      flush_ports <= next_flush_ports;
    end
  end

  assign o_flush_dyn = flush_dyn;
  assign o_flush_sta = flush_sta;
  assign o_flush_ports = flush_ports;

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign o_s_axi_arready = !rvalid;
  assign o_s_axi_rvalid = rvalid;
  assign o_s_axi_rdata = rdata;
  assign o_s_axi_rresp = rresp;
  assign ridx = reg_index(i_s_axi_araddr);

  // data held until the master takes it; one read at a time
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && i_s_axi_rready) begin
      next_rvalid = 1'b0;
    end else if (i_s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = is_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
      next_rdata = 32'h0;
      if (ridx == IDX_TAIL) begin
        next_rdata[TAIL_EN_BIT] = tail_en;
      end else if (ridx == IDX_P1_CTRL) begin
        next_rdata[2:0] = pctl[0];
      end else if (ridx == IDX_P2_CTRL) begin
        next_rdata[2:0] = pctl[1];
      end else if (ridx >= IDX_TOS_FIRST && ridx <= IDX_TOS_LAST) begin
        next_rdata[7:0] = tos[ridx[3:0]];
      end else if (ridx == IDX_STATUS) begin
        next_rdata[6:0] = {dec.valid, dec.fwd, dec.learn, dec.prio};
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // forwarding, learning and priority decision
  // ----------------------------------------------------------------
  // the decision never routes a frame back to its ingress port
  always_comb begin
    next_dec = '0;
    next_dec.valid = i_frm.valid;
    next_dec.prio = i_frm.is_ip ? dscp_prio : 2'h0;
    if (!i_frm.valid) begin
      next_dec = '0;
    end else if (i_frm.src == SRC_CPU) begin
      // processor port is outside stp control and always learns
      next_dec.learn = 1'b1;
      if (tail_en && i_frm.tail[1:0] != TAIL_LOOKUP) begin
        // directed frames pass in listening and learning as well
        next_dec.fwd = {1'b0, i_frm.tail[1:0]};
      end else begin
        next_dec.fwd = i_frm.dst & {1'b0, tx_en};
      end
      if (tail_en) begin
        next_dec.prio = i_frm.tail[3:2];
      end
    end else if (i_frm.src == SRC_P1 || i_frm.src == SRC_P2) begin
      next_dec.learn = !lrn_dis[i_frm.src[1]];
      if (i_frm.ovr) begin
        // override hits reach the processor whatever the port state
        next_dec.fwd = MASK_CPU;
      end else if (rx_en[i_frm.src[1]]) begin
        next_dec.fwd = i_frm.dst & {1'b1, tx_en} & ~{1'b0, i_frm.src};
      end else begin
        // blocking, listening, learning: processor traffic only
        next_dec.fwd = i_frm.dst & MASK_CPU;
      end
    end else begin
      next_dec.valid = 1'b1; // unknown source: dropped, not learned
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dec <= '0;
    end else begin
      dec <= next_dec;
    end
  end

  assign o_dec = dec;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_user_frame(logic [1:0] s);
    i_frm.valid && i_frm.src == s && !i_frm.ovr;
  endsequence

  AST_DSCP_PRIO: assert property (
    i_frm.valid && i_frm.is_ip && i_frm.src != SRC_CPU
    |=> o_dec.prio == $past(tos[i_frm.tos[7:4]][2*i_frm.tos[3:2] +: 2]))
    else $error("ip priority does not match code-point table");
  AST_TABLE_WRITE: assert property (
    do_write && w_lane && widx == IDX_TOS_FIRST |=> tos[0] == $past(w_byte))
    else $error("code-point table byte not stored");
  AST_CPU_DIRECTED: assert property (
    i_frm.valid && i_frm.src == SRC_CPU && tail_en && i_frm.tail[1:0] == 2'h2
    |=> o_dec.fwd == 3'h2 && o_dec.learn)
    else $error("directed processor frame was gated");
  AST_RX_OFF_CPU_ONLY: assert property (
    s_user_frame(SRC_P2) ##0 !rx_en[1] |=> (o_dec.fwd & 3'h3) == 3'h0)
    else $error("blocked port forwarded user traffic");
  AST_LEARN_FOLLOWS: assert property (
    i_frm.valid && i_frm.src == SRC_P1 |=> o_dec.learn == !$past(lrn_dis[0]))
    else $error("learning does not follow learn-disable");
  AST_FORWARDING: assert property (
    s_user_frame(SRC_P1) ##0 (pctl[0] == 3'h6 && tx_en[1])
    |=> o_dec.fwd == ($past(i_frm.dst) & 3'h6))
    else $error("forwarding port did not forward");
  AST_OVERRIDE: assert property (
    i_frm.valid && i_frm.ovr && i_frm.src != SRC_CPU && i_frm.src != 2'h0
    |=> o_dec.fwd == MASK_CPU && o_dec.valid)
    else $error("override frame not sent to processor");
  AST_FLUSH_PULSE: assert property (
    do_write && w_lane && widx == IDX_GLOBAL && w_byte[FLUSH_DYN_BIT] && lrn_dis == 2'h1
    |=> o_flush_dyn && o_flush_ports == 2'h1 ##1 !o_flush_dyn)
    else $error("flush strobe missing or not one cycle");
  AST_TAIL_OFF: assert property (
    i_frm.valid && i_frm.src == SRC_CPU && !tail_en && tx_en == 2'h3
    |=> o_dec.fwd == ($past(i_frm.dst) & 3'h3))
    else $error("tail byte used while tagging disabled");
endmodule

/* File: verif/host_cpu_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// host processor seen through the processor port
// ------------------------------------------------------------
module host_cpu_model (
  input wire logic i_ref_clk,
  input wire logic [1:0] i_block, // network ports held discarding
  input wire stp_dscp_pkg::frame_t i_frm,
  input wire stp_dscp_pkg::dec_t i_dec,
  output stp_dscp_pkg::frame_t o_frm,
  output int o_kept,
  output int o_dropped
);
  import stp_dscp_pkg::*;
  logic [1:0] src_q; // source of the frame behind the next decision
  logic blk_src; // that source is discarding

  initial begin
    o_frm = '0;
    o_kept = 0;
    o_dropped = 0;
    src_q = '0;
  end

  // one frame toward the switch; tail codes aimed at a discarding port
  // are cleared so nothing is ever steered there
  task automatic send(input logic [2:0] dst, input logic [7:0] tail);
    @(posedge i_ref_clk);
    o_frm <= '{valid: 1'b1, src: SRC_CPU, dst: dst, ovr: 1'b0, is_ip: 1'b0,
               tos: 8'h00, tail: {tail[7:2], tail[1:0] & ~i_block}};
    @(posedge i_ref_clk);
    o_frm.valid <= 1'b0;
  endtask

  assign blk_src = (src_q == SRC_P1 && i_block[0]) || (src_q == SRC_P2 && i_block[1]);

  // frames handed up from a discarding port are thrown away
  always @(posedge i_ref_clk) begin
    if (i_frm.valid === 1'b1) begin
      src_q <= i_frm.src;
    end
    if (i_dec.valid === 1'b1 && i_dec.fwd[2] === 1'b1) begin
      if (blk_src) begin
        o_dropped <= o_dropped + 1;
      end else begin
        o_kept <= o_kept + 1;
      end
    end
  end
endmodule

/* File: verif/port_stp_state_and_dscp_priority_tb.sv */
`timescale 1ns/1ps
module port_stp_state_and_dscp_priority_tb;
  import stp_dscp_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic i_ref_clk, i_nrst;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [8:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [3:0] wmask; // write strobes that wr offers
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  frame_t tb_frm, cpu_frm, frm; // bench frames, processor frames, merged
  dec_t dec;
  logic fl_dyn, fl_sta;
  logic [1:0] fl_ports, fp, blk;
  logic [7:0] tbl [16]; // expected code-point table
  logic [2:0] codes [3] = '{3'b001, 3'b000, 3'b110}; // discarding, learning, forwarding
  int n_errors, n_tests, n_fd, n_fs, kept, dropped;

  assign frm = (cpu_frm.valid === 1'b1) ? cpu_frm : tb_frm;

  stp_port_gate dut_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .i_frm(frm), .o_dec(dec),
    .o_flush_dyn(fl_dyn), .o_flush_sta(fl_sta), .o_flush_ports(fl_ports));

  host_cpu_model cpu_u (.i_ref_clk(i_ref_clk), .i_block(blk), .i_frm(frm), .i_dec(dec),
    .o_frm(cpu_frm), .o_kept(kept), .o_dropped(dropped));

  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  // flush pulses last one cycle, so count them at every edge
  always @(posedge i_ref_clk) begin
    if (fl_dyn === 1'b1) begin
      n_fd <= n_fd + 1;
      fp <= fl_ports;
    end
    if (fl_sta === 1'b1) begin
      n_fs <= n_fs + 1;
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    @(posedge i_ref_clk);
    awvalid <= 1'b1;
    awaddr <= 9'({idx, 2'b00});
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= wmask;
    while (a || w) begin
      @(posedge i_ref_clk);
      if (a && awready === 1'b1) begin
        a = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge i_ref_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
    @(posedge i_ref_clk);
    arvalid <= 1'b1;
    araddr <= 9'({idx, 2'b00});
    do @(posedge i_ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge i_ref_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", {24'h0, e}, rdata);
    chk("rresp", 32'(er), 32'(rresp));
  endtask

  // decision is looked at just after the edge that registers it
  task automatic ckd(input logic [2:0] ef, input logic el, input logic [1:0] ep);
    #1;
    chk("decision", 32'({1'b1, ef, el, ep}), 32'(dec));
  endtask

  task automatic fr(input logic [1:0] s, input logic [2:0] d, input logic o, input logic ip,
                    input logic [7:0] tos, input logic [2:0] ef, input logic el,
                    input logic [1:0] ep);
    @(posedge i_ref_clk);
    tb_frm <= '{1'b1, s, d, o, ip, tos, 8'h00};
    @(posedge i_ref_clk);
    tb_frm.valid <= 1'b0;
    ckd(ef, el, ep);
  endtask

  // same setting on both network ports
  task automatic st(input logic [2:0] v);
    wr(IDX_P1_CTRL, {5'h0, v}, RESP_OKAY);
    wr(IDX_P2_CTRL, {5'h0, v}, RESP_OKAY);
    blk <= {2{v == 3'b001}};
  endtask

  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    n_errors++;
    stop_test();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    logic [2:0] v, own, ef;
    i_nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    wmask = 4'hF;
    tb_frm = '0;
    {blk, fp} = '0;
    {n_errors, n_tests, n_fd, n_fs} = '0;
    repeat (20) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    // reset values and an unmapped index
    rd(IDX_P1_CTRL, {5'h0, PORT_CTRL_RST}, RESP_OKAY);
    rd(IDX_P2_CTRL, {5'h0, PORT_CTRL_RST}, RESP_OKAY);
    rd(IDX_TAIL, {1'b0, TAIL_EN_RST, 6'h0}, RESP_OKAY);
    rd(IDX_TOS_FIRST, TOS_RST, RESP_OKAY);
    rd(8'h01, 8'h00, RESP_SLVERR);
    wr(8'h01, 8'h5A, RESP_SLVERR);
    // fill the table, then classify every code point
    for (int i = 0; i < 16; i++) begin
      tbl[i] = 8'h1B + 8'(i * 37);
      wr(IDX_TOS_FIRST + 8'(i), tbl[i], RESP_OKAY);
    end
    rd(IDX_TOS_LAST, tbl[15], RESP_OKAY);
    for (int c = 0; c < 64; c++) begin
      fr(SRC_P1, 3'b110, 1'b0, 1'b1, {6'(c), 2'b11}, 3'b110, 1'b1, tbl[c / 4][2 * (c % 4) +: 2]);
    end
    fr(SRC_P2, 3'b001, 1'b0, 1'b0, 8'hFC, 3'b001, 1'b1, 2'b00);
    // a source outside ports 1..3 is dropped and not learned
    fr(2'b00, 3'b111, 1'b0, 1'b0, 8'h00, 3'b000, 1'b0, 2'b00);
    // discarding, learning and forwarding settings; override frames stand for the static entries
    for (int i = 0; i < 3; i++) begin
      v = codes[i];
      st(v);
      for (int p = 1; p < 3; p++) begin
        own = (p == 1) ? 3'b001 : 3'b010;
        ef = v[1] ? (~own & {1'b1, v[2], v[2]}) : 3'b100;
        fr(2'(p), 3'b111, 1'b0, 1'b0, 8'h00, ef, ~v[0], 2'b00);
        fr(2'(p), 3'b000, 1'b1, 1'b0, 8'h00, 3'b100, ~v[0], 2'b00);
      end
      cpu_u.send(3'b011, 8'h00);
      ckd(3'b011 & {1'b0, v[2], v[2]}, 1'b1, 2'b00);
    end
    chk("dropped", 32'd4, 32'(dropped));
    chk("kept", 32'd72, 32'(kept));
    // tail codes and tail priority
    wr(IDX_TAIL, 8'h40, RESP_OKAY);
    rd(IDX_TAIL, 8'h40, RESP_OKAY);
    for (int t = 0; t < 4; t++) begin
      cpu_u.send(3'b011, 8'(t * 5));
      ckd((t == 0) ? 3'b011 : {1'b0, 2'(t)}, 1'b1, 2'(t));
    end
    st(3'b001);
    cpu_u.send(3'b011, 8'h03);
    ckd(3'b000, 1'b1, 2'b00);
    // flush only acts while some port has learning off
    st(3'b110);
    wr(IDX_GLOBAL, 8'h30, RESP_OKAY);
    wr(IDX_P2_CTRL, 8'h01, RESP_OKAY);
    wr(IDX_GLOBAL, 8'h30, RESP_OKAY);
    wr(IDX_GLOBAL, 8'h10, RESP_OKAY);
    repeat (2) @(posedge i_ref_clk);
    chk("flush_dyn", 32'd2, 32'(n_fd));
    chk("flush_sta", 32'd1, 32'(n_fs));
    chk("flush_ports", 32'd2, 32'(fp));
    rd(IDX_GLOBAL, 8'h00, RESP_OKAY);
    // a write with the low lane off changes nothing
    wmask = 4'hE;
    wr(IDX_TAIL, 8'h00, RESP_OKAY);
    wmask = 4'hF;
    rd(IDX_TAIL, 8'h40, RESP_OKAY);
    // status shows the decision while frames keep arriving
    tb_frm <= '{1'b1, SRC_P1, 3'b110, 1'b0, 1'b0, 8'h00, 8'h00};
    rd(IDX_STATUS, 8'h64, RESP_OKAY);
    tb_frm.valid <= 1'b0;
    stop_test();
  end
endmodule
